// File: sivt_cfg.svh
// constants for the step interval / velocity threshold block
// assumes a 25 MHz system clock and a plain strobe register port
// Notes on behaviour
// - count clocks between 1/256 microsteps; expose as read-only 20-bit interval.
// - overflow or standstill reports the all-ones interval.
// - each hysteretic compare uses one sixteenth of threshold; current scaling checks the cool threshold without hysteresis.
// - reduced-hysteresis bit narrows every band to one thirty-second.
// - second compare value is T*15/16-1, or T*31/32-1 when reduced.
// - lower switching velocity equals threshold; upper is higher by hysteresis.
// - interval from internal controller is within one count of 2^24/V.
// - interval is per microstep, not averaged, in load-dependent speed mode.
// - interval at or above pwm threshold enables pwm chopper, blocks speed mode.
// - current scaling active only when lower threshold >= interval >= high threshold.
// - above load-adaptive threshold, enable stop-on-stall and stall output if set.
// - with speed mode not configured, drop them again below that threshold.
// - interval below high threshold disables current scaling and pwm chopper.
`ifndef SIVT_CFG_SVH
`define SIVT_CFG_SVH
`define SIVT_ADDR_W            8
`define SIVT_OFS_INTERVAL      8'h12
`define SIVT_OFS_PWM_THRS      8'h13
`define SIVT_OFS_COOL_THRS     8'h14
`define SIVT_OFS_HIGH_THRS     8'h15
`define SIVT_OFS_CTRL          8'h40
`define SIVT_OFS_IRQ_STATUS    8'h41
`define SIVT_OFS_IRQ_MASK      8'h42
`define SIVT_OFS_STATE         8'h43
`define SIVT_CTRL_SMALL_HYST   0
`define SIVT_CTRL_PWM_CFG      1
`define SIVT_CTRL_COOL_CFG     2
`define SIVT_CTRL_STOP_CFG     3
`define SIVT_CTRL_DIAG_CFG     4
`define SIVT_CTRL_SPEED_CFG    5
`define SIVT_CTRL_W            6
`define SIVT_IRQ_W             4
`define SIVT_THRS_RESET        20'h00000
`define SIVT_INTERVAL_RESET    20'hFFFFF
`endif

// File: sivt_hyst_cmp.sv
// one hysteretic compare of the step interval against a threshold
// assumes interval and threshold come from registers on the same clock
`timescale 1ns/1ns
`default_nettype none
module sivt_hyst_cmp
(
   input  wire logic                    ref_clk,
   input  wire logic                    nrst,
   input  wire sivt_pkg::sivt_interval_t interval,
   input  wire sivt_pkg::sivt_interval_t threshold,
   input  wire logic                    small_hyst,
   output var  logic                    slow
);
   import sivt_pkg::*;
   typedef struct packed
   {
      logic slow;
   } sivt_cmp_state_t;

   sivt_cmp_state_t  st;
   sivt_cmp_state_t  next_st;
   logic [20:0]      low_cmp;
   logic [24:0]      prod_16;
   logic [25:0]      prod_32;

   // slow means interval >= threshold (velocity at or below the threshold)
   always_comb
   begin
      next_st = st;
      // floor of T*15/16 and T*31/32; a negative result sets bit 20
      prod_16 = {1'b0, threshold, 4'h0} - {5'h00, threshold};
      prod_32 = {1'b0, threshold, 5'h00} - {6'h00, threshold};
      if (small_hyst)
         low_cmp = prod_32[25:5] - 21'h000001;
      else
         low_cmp = prod_16[24:4] - 21'h000001;
      // enter slow at threshold, leave only at or below lower value
      if ({1'b0, interval} >= {1'b0, threshold})
         next_st.slow = 1'b1;
      else if (low_cmp[20] || ({1'b0, interval} <= low_cmp))
         next_st.slow = 1'b0;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      // interval resets saturated, so start on the slow side: no false mode event
      if (!nrst)
         st <= '1;
      else
         st <= next_st;
   end

   assign slow = st.slow;
endmodule : sivt_hyst_cmp
`default_nettype wire

// File: sivt_pkg.sv
// types shared by the step interval / velocity threshold block
package sivt_pkg;
   typedef logic [19:0] sivt_interval_t;
   typedef logic [7:0]  sivt_addr_t;
   typedef logic [31:0] sivt_word_t;
endpackage : sivt_pkg

// File: sivt_properties.sv
// port checker for the step interval block
// assumes it is bound onto sivt_top
`timescale 1ns/1ns
`default_nettype none
module sivt_properties
(
   input wire logic                 ref_clk,
   input wire logic                 nrst,
   input wire logic                 step_pulse,
   input wire logic                 standstill,
   input wire sivt_pkg::sivt_addr_t reg_addr,
   input wire sivt_pkg::sivt_word_t reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire sivt_pkg::sivt_word_t reg_rdata,
   input wire logic                 pwm_chopper_en,
   input wire logic                 speed_mode_en,
   input wire logic                 irq
);
   import sivt_pkg::*;
   logic [20:0] gap;
   logic [19:0] expv;
   logic        seen;
   logic        ok;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // ----------------------------------------
   // interval model, trusted until standstill
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         gap  <= 21'h000000;
         expv <= 20'hFFFFF;
         seen <= 1'b0;
         ok   <= 1'b1;
      end
      else
      begin
         gap  <= step_pulse ? 21'h000001 : (gap[20] ? gap : gap + 21'h000001);
         seen <= seen | step_pulse;
         ok   <= ok & !standstill;
         if (step_pulse)
            expv <= (seen && !gap[20]) ? gap[19:0] : 20'hFFFFF;
         else if (gap[20])
            expv <= 20'hFFFFF;
      end
   end
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
      else $error("read data not zero outside an answer");
   AST_UNMAPPED: assert property ($past(reg_rd && reg_addr == 8'h00) |-> reg_rdata == 32'h00000000)
      else $error("unmapped read not zero");
   AST_UPPER_ZERO: assert property ($past(reg_rd && reg_addr inside {[8'h12:8'h15]}) |-> reg_rdata[31:20] == 12'h000)
      else $error("upper read bits not zero");
   AST_READBACK: assert property ($past(reg_wr, 2) && $past(reg_rd) && $past(reg_addr) == $past(reg_addr, 2)
      && $past(reg_addr) inside {[8'h13:8'h15]} |-> reg_rdata == ($past(reg_wdata, 2) & 32'h000FFFFF))
      else $error("threshold read back differs");
   AST_INTERVAL: assert property ($past(ok) && $past(reg_rd && reg_addr == 8'h12) |-> reg_rdata == {12'h000, $past(expv)})
      else $error("step interval differs from pulse spacing");
   AST_STANDSTILL: assert property ($past(standstill, 2) && $past(standstill) && $past(reg_rd && reg_addr == 8'h12)
      |-> reg_rdata == 32'h000FFFFF)
      else $error("standstill interval not saturated");
   AST_MODE_EXCL: assert property (!(pwm_chopper_en && speed_mode_en))
      else $error("pwm chopper and speed mode both on");
   AST_IRQ_MASKED: assert property ($past(reg_wr && reg_addr == 8'h42 && reg_wdata[3:0] == 4'h0) |-> !irq)
      else $error("irq high with all sources masked");
endmodule : sivt_properties
bind sivt_top sivt_properties sivt_properties_i (.ref_clk, .nrst, .step_pulse, .standstill, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .pwm_chopper_en, .speed_mode_en, .irq);
`default_nettype wire

// File: sivt_top.sv
// step interval measurement and velocity threshold mode gating
// assumes step_pulse is a one-cycle pulse per 1/256 microstep on ref_clk
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "sivt_cfg.svh"
module sivt_top
(
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire logic                 step_pulse,
   input  wire logic                 standstill,
   input  wire sivt_pkg::sivt_addr_t reg_addr,
   input  wire sivt_pkg::sivt_word_t reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output var  sivt_pkg::sivt_word_t reg_rdata,
   output var  logic                 pwm_chopper_en,
   output var  logic                 speed_mode_en,
   output var  logic                 current_scale_en,
   output var  logic                 stop_on_stall_enable,
   output var  logic                 stall_diag_en,
   output var  logic                 irq
);
   import sivt_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed
   {
      logic [20:0]            count;
      sivt_interval_t         interval;
      logic                   seen_step;
      sivt_interval_t         pwm_thrs;
      sivt_interval_t         cool_thrs;
      sivt_interval_t         high_thrs;
      logic [`SIVT_CTRL_W-1:0] ctrl;
      logic [`SIVT_IRQ_W-1:0]  irq_status;
      logic [`SIVT_IRQ_W-1:0]  irq_mask;
      logic                   stall_armed;
      logic [3:0]             modes_q;
      sivt_word_t             rdata;
   } sivt_state_t;

   sivt_state_t st;
   sivt_state_t next_st;

   logic                   above_pwm;
   logic                   above_cool;
   logic                   above_high;
   logic [3:0]             modes;
   logic [`SIVT_IRQ_W-1:0] events;

   // ----------------------------------------
   // threshold comparators, one per threshold
   // ----------------------------------------
   sivt_hyst_cmp u_cmp_pwm
   (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .interval   (st.interval),
      .threshold  (st.pwm_thrs),
      .small_hyst (st.ctrl[`SIVT_CTRL_SMALL_HYST]),
      .slow       (above_pwm)
   );

   sivt_hyst_cmp u_cmp_cool
   (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .interval   (st.interval),
      .threshold  (st.cool_thrs),
      .small_hyst (st.ctrl[`SIVT_CTRL_SMALL_HYST]),
      .slow       (above_cool)
   );

   sivt_hyst_cmp u_cmp_high
   (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .interval   (st.interval),
      .threshold  (st.high_thrs),
      .small_hyst (st.ctrl[`SIVT_CTRL_SMALL_HYST]),
      .slow       (above_high)
   );

   // ----------------------------------------
   // mode gating
   // ----------------------------------------
   // above_x: interval >= x (slow side); cool must be compared unsigned
   always_comb
   begin
      // pwm only above pwm threshold and above high threshold
      pwm_chopper_en   = st.ctrl[`SIVT_CTRL_PWM_CFG] && above_pwm && above_high;
      // speed mode blocked on the slow side of the pwm threshold
      speed_mode_en    = st.ctrl[`SIVT_CTRL_SPEED_CFG] && !above_pwm;
      // window between high and load-adaptive thresholds
      current_scale_en = st.ctrl[`SIVT_CTRL_COOL_CFG] && above_high &&
                         ({1'b0, st.cool_thrs} >= {1'b0, st.interval});
      stop_on_stall_enable = st.ctrl[`SIVT_CTRL_STOP_CFG] && st.stall_armed;
      stall_diag_en        = st.ctrl[`SIVT_CTRL_DIAG_CFG] && st.stall_armed;
      modes  = {current_scale_en, speed_mode_en, pwm_chopper_en, st.stall_armed};
      events = modes ^ st.modes_q;
   end

   // ----------------------------------------
   // measurement, registers and interrupts
   // ----------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.rdata = '0;

      // counts clocks since last step, reloads on each step
      if (step_pulse)
      begin
         next_st.seen_step = 1'b1;
         if (!st.seen_step || st.count[20] || (&st.count[19:0]))
            next_st.interval = `SIVT_INTERVAL_RESET;
         else
            next_st.interval = st.count[19:0] + 20'h00001;
         next_st.count = '0;
      end
      else if (!st.count[20])
         next_st.count = st.count + 21'h000001;
      // saturate once counter overflows or motor stands still
      if (standstill || (st.count[20] && !step_pulse))
         next_st.interval = `SIVT_INTERVAL_RESET;

      // a velocity crossing above the load-adaptive threshold arms stall logic
      if (!above_cool)
         next_st.stall_armed = 1'b1;
      else if (!st.ctrl[`SIVT_CTRL_SPEED_CFG])
         next_st.stall_armed = 1'b0;

      next_st.modes_q = modes;

      if (reg_wr)
      begin
         case (reg_addr)
            `SIVT_OFS_PWM_THRS:   next_st.pwm_thrs   = reg_wdata[19:0];
            `SIVT_OFS_COOL_THRS:  next_st.cool_thrs  = reg_wdata[19:0];
            `SIVT_OFS_HIGH_THRS:  next_st.high_thrs  = reg_wdata[19:0];
            `SIVT_OFS_CTRL:       next_st.ctrl       = reg_wdata[`SIVT_CTRL_W-1:0];
            `SIVT_OFS_IRQ_STATUS: next_st.irq_status = st.irq_status & ~reg_wdata[`SIVT_IRQ_W-1:0];
            `SIVT_OFS_IRQ_MASK:   next_st.irq_mask   = reg_wdata[`SIVT_IRQ_W-1:0];
            default:              next_st.ctrl       = st.ctrl;
         endcase
      end
      // set wins over a clear in the same cycle
      next_st.irq_status = next_st.irq_status | events;

      if (reg_rd)
      begin
         case (reg_addr)
            `SIVT_OFS_INTERVAL:   next_st.rdata = {12'h000, st.interval};
            `SIVT_OFS_PWM_THRS:   next_st.rdata = {12'h000, st.pwm_thrs};
            `SIVT_OFS_COOL_THRS:  next_st.rdata = {12'h000, st.cool_thrs};
            `SIVT_OFS_HIGH_THRS:  next_st.rdata = {12'h000, st.high_thrs};
            `SIVT_OFS_CTRL:       next_st.rdata = {26'h0, st.ctrl};
            `SIVT_OFS_IRQ_STATUS: next_st.rdata = {28'h0000000, st.irq_status};
            `SIVT_OFS_IRQ_MASK:   next_st.rdata = {28'h0000000, st.irq_mask};
            `SIVT_OFS_STATE:      next_st.rdata = {25'h0, above_high, above_cool, above_pwm, modes};
            default:              next_st.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st          <= '0;
         st.interval <= `SIVT_INTERVAL_RESET;
      end
      else
         st <= next_st;
   end

   assign reg_rdata = st.rdata;
   assign irq       = |(st.irq_status & st.irq_mask);
endmodule : sivt_top
`default_nettype wire

// File: sivt_top_tb.sv
// self-checking bench for sivt_top
// assumes the port checker is bound in from its own file
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s exp %h got %h", n, e, g); end end
module sivt_top_tb;
   import sivt_pkg::*;
   logic       ref_clk, nrst, step_pulse, standstill, reg_wr, reg_rd;
   logic       pwm_chopper_en, speed_mode_en, current_scale_en, stop_on_stall_enable, stall_diag_en, irq;
   sivt_addr_t reg_addr;
   sivt_word_t reg_wdata, reg_rdata;
   int         mismatches, comparisons, cycles, last_step;
   int         gaps[10]  = '{40, 30, 29, 31, 32, 40, 30, 31, 40, 40};
   logic [4:0] modes[10] = '{5'h10, 5'h17, 5'h0F, 5'h0F, 5'h17, 5'h13, 5'h0F, 5'h0F, 5'h10, 5'h00};
   sivt_addr_t ra[6]     = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h42, 8'h00};
   sivt_top sivt_top_i (.ref_clk, .nrst, .step_pulse, .standstill, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .pwm_chopper_en, .speed_mode_en, .current_scale_en, .stop_on_stall_enable, .stall_diag_en, .irq);
   // ----------------------------------------
   // bus and step drivers
   // ----------------------------------------
   task automatic wr(input sivt_addr_t a, input sivt_word_t d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd_chk(input sivt_addr_t a, input sivt_word_t e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
   endtask : rd_chk
   // write and read back with no idle cycle between the strobes
   task automatic wr_rd_chk(input sivt_addr_t a, input sivt_word_t d, input sivt_word_t e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
   endtask : wr_rd_chk
   // pulse lands n edges after the previous one; bus work between stays shorter
   task automatic step(input int n);
      @(posedge ref_clk);
      while (cycles < last_step + n - 1)
         @(posedge ref_clk);
      step_pulse <= 1'b1;
      @(posedge ref_clk);
      last_step = cycles;
      step_pulse <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : step
   task automatic print_verdict();
      $display("counts: %0d compared, %0d mismatched", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // whole run is well under 2000 cycles
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         print_verdict();
      end
   end
   initial
   begin
      {nrst, step_pulse, standstill, reg_wr, reg_rd} = 5'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++)
         rd_chk(ra[i], (i == 0) ? 32'h000FFFFF : 32'h00000000);
      $display("test reset done");
      wr_rd_chk(8'h13, 32'hFFF00020, 32'h00000020);
      wr(8'h14, 32'h00000024);
      step(4);
      rd_chk(8'h12, 32'h000FFFFF);
      step(10);
      step(10);
      wr(8'h12, 32'h00000005);
      rd_chk(8'h12, 32'h0000000A);
      @(posedge ref_clk);
      standstill <= 1'b1;
      rd_chk(8'h12, 32'h000FFFFF);
      @(posedge ref_clk);
      standstill <= 1'b0;
      $display("test interval done");
      wr(8'h40, 32'h0000003E);
      for (int i = 0; i < 10; i++)
      begin
         if (i == 5)
            wr(8'h40, 32'h0000003F);
         if (i == 8)
            wr(8'h40, 32'h0000001E);
         if (i == 9)
            wr(8'h15, 32'h00000030);
         step(gaps[i]);
         `CHK("modes", modes[i], {pwm_chopper_en, speed_mode_en, current_scale_en, stop_on_stall_enable, stall_diag_en})
      end
      rd_chk(8'h40, 32'h0000001E);
      rd_chk(8'h43, 32'h00000030);
      $display("test thresholds done");
      rd_chk(8'h41, 32'h0000000F);
      `CHK("irq", 1'b0, irq)
      wr(8'h42, 32'h00000001);
      `CHK("irq", 1'b1, irq)
      wr(8'h42, 32'h00000000);
      `CHK("irq", 1'b0, irq)
      wr(8'h41, 32'h0000000F);
      rd_chk(8'h41, 32'h00000000);
      wr(8'h42, 32'h0000000F);
      `CHK("irq", 1'b0, irq)
      $display("test irq done");
      print_verdict();
   end
endmodule : sivt_top_tb
`default_nettype wire
